/* lamp_pkg.sv */
package lamp_pkg;

  // ==========================================================================
  // sizes
  // ==========================================================================
  localparam int NUM_LAMPS     = 7;
  localparam int NUM_SLOTS     = 5;
  localparam int SEL_W         = 6;
  localparam int NUM_SOURCES   = 64;

  // ==========================================================================
  // colour and latch encodings
  // ==========================================================================
  typedef enum logic [1:0] {
    COLOUR_GREEN       = 2'h0,
    COLOUR_RED         = 2'h1,
    COLOUR_RED_FLASH   = 2'h2,
    COLOUR_GREEN_FLASH = 2'h3
  } colour_t;

  typedef enum logic [1:0] {
    LATCH_NONE  = 2'h0,
    LATCH_ACK   = 2'h1,
    LATCH_ALARM = 2'h2
  } latch_t;

  localparam colour_t ON_COLOUR_RST  = COLOUR_RED;
  localparam colour_t OFF_COLOUR_RST = COLOUR_GREEN;
  localparam latch_t  LATCH_RST      = LATCH_NONE;

  // ==========================================================================
  // register map (byte addresses)
  // ==========================================================================
  localparam int          LAMP_STRIDE   = 32;
  localparam logic [7:0]  OFS_SLOT_SEL  = 8'h00;
  localparam logic [7:0]  OFS_INVERT    = 8'h04;
  localparam logic [7:0]  OFS_MODE      = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0c;
  localparam logic [7:0]  OFS_BLINK     = 8'he0;
  localparam int          ADDR_W        = 8;

  // mode register fields
  localparam int MODE_ON_LSB    = 0;
  localparam int MODE_OFF_LSB   = 2;
  localparam int MODE_LATCH_LSB = 4;
  localparam int MODE_ACK_LSB   = 8;
  // status register fields
  localparam int STAT_SLOT_LSB  = 0;
  localparam int STAT_ACK_BIT   = 5;
  localparam int STAT_LIT_BIT   = 6;
  localparam int STAT_HELD_BIT  = 7;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================================
  // blink timing
  // ==========================================================================
  localparam int BLINK_HALF_MS     = 500;
  localparam int CLOCK_HZ          = 20_000_000;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * (CLOCK_HZ / 1000);

endpackage

/* lamp_channel.sv */
`timescale 1ns/1ps
module lamp_channel
  import lamp_pkg::*;
(
  // clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_srst,
  // configuration
  input  wire logic [NUM_SOURCES-1:0] i_sources,
  input  wire logic [NUM_SLOTS*SEL_W-1:0] i_slot_sel,
  input  wire logic [NUM_SLOTS-1:0]  i_invert,
  input  wire logic [SEL_W-1:0]      i_ack_sel,
  input  wire latch_t                i_latch,
  input  wire colour_t               i_on_colour,
  input  wire colour_t               i_off_colour,
  input  wire logic                  i_blink,
  // results
  output logic [NUM_SLOTS-1:0]       o_slot_state,
  output logic                       o_ack_state,
  output logic                       o_lit,
  output logic                       o_held,
  output logic                       o_red,
  output logic                       o_green
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [NUM_SLOTS-1:0] slot;
    logic                 ack;
    logic                 lit;
    logic                 held;
    logic                 red;
    logic                 green;
  } chan_t;

  chan_t chan_reg;
  chan_t chan_next;

  always_comb begin
    logic    any;
    logic    ack_in;
    logic    active;
    colour_t col;
    any = 1'b0;
    ack_in = 1'b0;
    active = 1'b0;
    col = COLOUR_GREEN;
    chan_next = chan_reg;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      chan_next.slot[s] = i_sources[i_slot_sel[s*SEL_W +: SEL_W]] ^ i_invert[s];
    end
    any = |chan_next.slot;
    // the ack is the raw source only in ack-latching mode; alarm and non-latching modes see 0
    ack_in = (i_latch == LATCH_ACK) ? i_sources[i_ack_sel] : 1'b0;
    chan_next.ack = ack_in;
    if (i_latch == LATCH_NONE) begin
      chan_next.held = 1'b0;
    end else if (any) begin
      chan_next.held = 1'b1;
    end else if (i_latch == LATCH_ACK && ack_in) begin
      chan_next.held = 1'b0;
    end else if (i_latch == LATCH_ALARM && chan_reg.lit && !any && ack_in) begin
      chan_next.held = 1'b0;
    end
    active = any | chan_next.held;
    chan_next.lit = active;
    col = active ? i_on_colour : i_off_colour;
    case (col)
      COLOUR_GREEN: begin
        chan_next.red = 1'b0;
        chan_next.green = 1'b1;
      end
      COLOUR_RED: begin
        chan_next.red = 1'b1;
        chan_next.green = 1'b0;
      end
      COLOUR_RED_FLASH: begin
        chan_next.red = i_blink;
        chan_next.green = 1'b0;
      end
      default: begin
        chan_next.red = 1'b0;
        chan_next.green = i_blink;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      chan_reg <= '0;
    end else begin
      chan_reg <= chan_next;
    end
  end

  assign o_slot_state = chan_reg.slot;
  assign o_ack_state  = chan_reg.ack;
  assign o_lit        = chan_reg.lit;
  assign o_held       = chan_reg.held;
  assign o_red        = chan_reg.red;
  assign o_green      = chan_reg.green;

endmodule

/* led_indicator_logic.sv */
// Behaviour
// - five selectable slots, each state readable
// - per-slot invert, default off
// - OR true shows the on colour
// - OR false shows the off colour
// - three latch modes, default non-latching
// - acknowledge clears only after inputs gone, and only in ack-latching mode
// - ack source selectable, used only in ack-latching mode
// - ack input state reported per lamp in ack-latching mode, as 0 in the other modes
`timescale 1ns/1ps
module led_indicator_logic
  import lamp_pkg::*;
#(
  parameter int BLINK_HALF = BLINK_HALF_CYCLES
) (
  // clock and reset
  input  wire logic                         i_clock,
  input  wire logic                         i_srst,
  // internal signal list
  input  wire logic [NUM_SOURCES-1:0]       i_sources,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]            i_awaddr,
  input  wire logic                         i_awvalid,
  output logic                              o_awready,
  // axi4-lite write data
  input  wire logic [31:0]                  i_wdata,
  input  wire logic [3:0]                   i_wstrb,
  input  wire logic                         i_wvalid,
  output logic                              o_wready,
  // axi4-lite write response
  output logic [1:0]                        o_bresp,
  output logic                              o_bvalid,
  input  wire logic                         i_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0]            i_araddr,
  input  wire logic                         i_arvalid,
  output logic                              o_arready,
  // axi4-lite read data
  output logic [31:0]                       o_rdata,
  output logic [1:0]                        o_rresp,
  output logic                              o_rvalid,
  input  wire logic                         i_rready,
  // lamps and status signals
  output logic [NUM_LAMPS-1:0]              o_red,
  output logic [NUM_LAMPS-1:0]              o_green,
  output logic [NUM_LAMPS*NUM_SLOTS-1:0]    o_slot_state,
  output logic [NUM_LAMPS-1:0]              o_ack_state
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [NUM_LAMPS-1:0][NUM_SLOTS*SEL_W-1:0] sel;
    logic [NUM_LAMPS-1:0][NUM_SLOTS-1:0]       inv;
    logic [NUM_LAMPS-1:0][1:0]                 on_c;
    logic [NUM_LAMPS-1:0][1:0]                 off_c;
    logic [NUM_LAMPS-1:0][1:0]                 latch;
    logic [NUM_LAMPS-1:0][SEL_W-1:0]           ack_sel;
    logic [31:0]                               blink_cnt;
    logic                                      blink;
    logic [ADDR_W-1:0]                         awaddr;
    logic                                      aw_got;
    logic [31:0]                               wdata;
    logic [3:0]                                wstrb;
    logic                                      w_got;
    logic                                      bvalid;
    logic [1:0]                                bresp;
    logic                                      rvalid;
    logic [31:0]                               rdata;
    logic [1:0]                                rresp;
    logic                                      awready;
    logic                                      wready;
    logic                                      arready;
  } top_t;

  top_t top_reg;
  top_t top_next;

  logic [NUM_LAMPS-1:0][NUM_SLOTS-1:0] slot_w;
  logic [NUM_LAMPS-1:0]                ack_w;
  logic [NUM_LAMPS-1:0]                lit_w;
  logic [NUM_LAMPS-1:0]                held_w;
  logic [NUM_LAMPS-1:0]                red_w;
  logic [NUM_LAMPS-1:0]                green_w;

  // merges a byte-enabled write into a word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // lamp channels
  // ==========================================================================
  for (genvar l = 0; l < NUM_LAMPS; l++) begin : g_lamp
    lamp_channel u_chan (
      .i_clock      (i_clock),
      .i_srst       (i_srst),
      .i_sources    (i_sources),
      .i_slot_sel   (top_reg.sel[l]),
      .i_invert     (top_reg.inv[l]),
      .i_ack_sel    (top_reg.ack_sel[l]),
      .i_latch      (latch_t'(top_reg.latch[l])),
      .i_on_colour  (colour_t'(top_reg.on_c[l])),
      .i_off_colour (colour_t'(top_reg.off_c[l])),
      .i_blink      (top_reg.blink),
      .o_slot_state (slot_w[l]),
      .o_ack_state  (ack_w[l]),
      .o_lit        (lit_w[l]),
      .o_held       (held_w[l]),
      .o_red        (red_w[l]),
      .o_green      (green_w[l])
    );
  end

  // ==========================================================================
  // blink, bus and registers
  // ==========================================================================
  always_comb begin
    logic [ADDR_W-1:0] a;
    logic [31:0]       cur;
    logic [31:0]       m;
    logic              hit;
    int                idx;
    a = '0;
    cur = '0;
    m = '0;
    hit = 1'b0;
    idx = 0;
    top_next = top_reg;

    // common blink enable
    if (top_reg.blink_cnt >= 32'(BLINK_HALF - 1)) begin
      top_next.blink_cnt = '0;
      top_next.blink = ~top_reg.blink;
    end else begin
      top_next.blink_cnt = top_reg.blink_cnt + 32'h1;
    end

    // write channels
    if (i_awvalid && !top_reg.aw_got && !top_reg.bvalid) begin
      top_next.awaddr = i_awaddr;
      top_next.aw_got = 1'b1;
    end
    if (i_wvalid && !top_reg.w_got && !top_reg.bvalid) begin
      top_next.wdata = i_wdata;
      top_next.wstrb = i_wstrb;
      top_next.w_got = 1'b1;
    end
    if (top_reg.bvalid && i_bready) begin
      top_next.bvalid = 1'b0;
    end
    if (top_reg.aw_got && top_reg.w_got) begin
      top_next.aw_got = 1'b0;
      top_next.w_got = 1'b0;
      top_next.bvalid = 1'b1;
      a = top_reg.awaddr;
      idx = int'(a) / LAMP_STRIDE;
      hit = (a[1:0] == 2'h0) && (idx < NUM_LAMPS);
      if (hit) begin
        if (a[4:0] == OFS_SLOT_SEL[4:0]) begin
          m = merge(32'(top_reg.sel[idx]), top_reg.wdata, top_reg.wstrb);
          top_next.sel[idx] = m[NUM_SLOTS*SEL_W-1:0];
        end else if (a[4:0] == OFS_INVERT[4:0]) begin
          m = merge(32'(top_reg.inv[idx]), top_reg.wdata, top_reg.wstrb);
          top_next.inv[idx] = m[NUM_SLOTS-1:0];
        end else if (a[4:0] == OFS_MODE[4:0]) begin
          cur = {18'h0, top_reg.ack_sel[idx], 2'h0, top_reg.latch[idx],
                 top_reg.off_c[idx], top_reg.on_c[idx]};
          m = merge(cur, top_reg.wdata, top_reg.wstrb);
          top_next.on_c[idx] = m[MODE_ON_LSB +: 2];
          top_next.off_c[idx] = m[MODE_OFF_LSB +: 2];
          top_next.latch[idx] = (m[MODE_LATCH_LSB +: 2] == 2'h3) ? 2'(LATCH_NONE)
                                                                : m[MODE_LATCH_LSB +: 2];
          top_next.ack_sel[idx] = m[MODE_ACK_LSB +: SEL_W];
        end else if (a[4:0] != OFS_STATUS[4:0]) begin
          hit = 1'b0;
        end
      end
      top_next.bresp = hit ? RESP_OKAY : RESP_SLVERR;
    end

    // read channel
    if (top_reg.rvalid && i_rready) begin
      top_next.rvalid = 1'b0;
    end
    if (i_arvalid && !top_reg.rvalid) begin
      a = i_araddr;
      idx = int'(a) / LAMP_STRIDE;
      top_next.rvalid = 1'b1;
      top_next.rresp = RESP_OKAY;
      top_next.rdata = '0;
      if (a == OFS_BLINK) begin
        top_next.rdata = {31'h0, top_reg.blink};
      end else if (a[1:0] != 2'h0 || idx >= NUM_LAMPS) begin
        top_next.rresp = RESP_SLVERR;
      end else if (a[4:0] == OFS_SLOT_SEL[4:0]) begin
        top_next.rdata = 32'(top_reg.sel[idx]);
      end else if (a[4:0] == OFS_INVERT[4:0]) begin
        top_next.rdata = 32'(top_reg.inv[idx]);
      end else if (a[4:0] == OFS_MODE[4:0]) begin
        top_next.rdata = {18'h0, top_reg.ack_sel[idx], 2'h0, top_reg.latch[idx],
                          top_reg.off_c[idx], top_reg.on_c[idx]};
      end else if (a[4:0] == OFS_STATUS[4:0]) begin
        top_next.rdata = {24'h0, held_w[idx], lit_w[idx], ack_w[idx], slot_w[idx]};
      end else begin
        top_next.rresp = RESP_SLVERR;
      end
    end

    // readies are registered so that every port comes from a flip-flop
    top_next.awready = !top_next.aw_got && !top_next.bvalid;
    top_next.wready = !top_next.w_got && !top_next.bvalid;
    top_next.arready = !top_next.rvalid;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      top_reg <= '0;
      top_reg.awready <= 1'b1;
      top_reg.wready <= 1'b1;
      top_reg.arready <= 1'b1;
      for (int l = 0; l < NUM_LAMPS; l++) begin
        top_reg.on_c[l] <= ON_COLOUR_RST;
        top_reg.off_c[l] <= OFF_COLOUR_RST;
        top_reg.latch[l] <= LATCH_RST;
      end
    end else begin
      top_reg <= top_next;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign o_awready    = top_reg.awready;
  assign o_wready     = top_reg.wready;
  assign o_bvalid     = top_reg.bvalid;
  assign o_bresp      = top_reg.bresp;
  assign o_arready    = top_reg.arready;
  assign o_rvalid     = top_reg.rvalid;
  assign o_rdata      = top_reg.rdata;
  assign o_rresp      = top_reg.rresp;
  assign o_red        = red_w;
  assign o_green      = green_w;
  assign o_slot_state = slot_w;
  assign o_ack_state  = ack_w;

endmodule

/* led_indicator_logic_properties.sv */
`timescale 1ns/1ps
module led_indicator_logic_checker
  import lamp_pkg::*;
#(
  parameter int BLINK_HALF = BLINK_HALF_CYCLES
) (
  input wire logic                 i_clock,
  input wire logic                 i_srst,
  input wire logic                 i_awvalid,
  input wire logic                 o_awready,
  input wire logic                 i_wvalid,
  input wire logic                 o_wready,
  input wire logic [1:0]           o_bresp,
  input wire logic                 o_bvalid,
  input wire logic                 i_bready,
  input wire logic [ADDR_W-1:0]    i_araddr,
  input wire logic                 i_arvalid,
  input wire logic                 o_arready,
  input wire logic [31:0]          o_rdata,
  input wire logic [1:0]           o_rresp,
  input wire logic                 o_rvalid,
  input wire logic                 i_rready,
  input wire logic [NUM_LAMPS-1:0] o_red,
  input wire logic [NUM_LAMPS-1:0] o_green
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);

  // ==========================================================================
  // bus handshakes and lamp colours
  // ==========================================================================
  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_taken;
    i_arvalid && o_arready;
  endsequence
  property p_ar_answer;
    s_rd_taken |=> o_rvalid;
  endproperty
  property p_r_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp);
  endproperty
  property p_ar_block;
    o_rvalid |-> !o_arready;
  endproperty
  property p_r_release;
    o_rvalid && i_rready |=> !o_rvalid && o_arready;
  endproperty
  property p_b_timing;
    s_wr_taken |=> !o_bvalid ##1 o_bvalid;
  endproperty
  property p_b_hold;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  property p_w_block;
    o_bvalid |-> !o_awready && !o_wready;
  endproperty
  property p_unaligned_rd;
    s_rd_taken ##0 (i_araddr[1:0] != 2'h0) |=> o_rresp == RESP_SLVERR;
  endproperty
  property p_one_colour;
    (o_red & o_green) == '0;
  endproperty

  a_ar_answer: assert property (p_ar_answer)
    else $error("read data not returned one cycle after address");
  a_r_hold: assert property (p_r_hold)
    else $error("read data changed before it was taken");
  a_ar_block: assert property (p_ar_block)
    else $error("read address accepted while data pending");
  a_r_release: assert property (p_r_release)
    else $error("read channel not freed after data taken");
  a_b_timing: assert property (p_b_timing)
    else $error("write response not two cycles after write");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before it was taken");
  a_w_block: assert property (p_w_block)
    else $error("write accepted while response pending");
  a_unaligned_rd: assert property (p_unaligned_rd)
    else $error("unaligned read not refused");
  a_one_colour: assert property (p_one_colour)
    else $error("lamp driven red and green at once");
endmodule

bind led_indicator_logic led_indicator_logic_checker #(.BLINK_HALF(BLINK_HALF)) u_checker (
  .i_clock(i_clock), .i_srst(i_srst), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
  .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
  .o_red(o_red), .o_green(o_green));

/* test_led_indicator_logic.sv */
`timescale 1ns/1ps
module test_led_indicator_logic
  import lamp_pkg::*;
();
  localparam int HALF = 4;
  logic                             i_clock = 1'b0;
  logic                             i_srst = 1'b1;
  logic [NUM_SOURCES-1:0]           sources = '0;
  logic [7:0]                       awaddr = '0, araddr = '0;
  logic [31:0]                      wdata = '0, rdata;
  logic [3:0]                       wstrb = '0;
  logic                             awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic                             awready, wready, bvalid, arready, rvalid;
  logic [1:0]                       bresp, rresp;
  logic [NUM_LAMPS-1:0]             o_red, o_green, o_ack_state;
  logic [NUM_LAMPS*NUM_SLOTS-1:0]   o_slot_state;
  int                               n_errors = 0;
  int                               checks_done = 0;

  always #25 i_clock = ~i_clock;

  led_indicator_logic #(.BLINK_HALF(HALF)) DUT (
    .i_clock(i_clock), .i_srst(i_srst), .i_sources(sources),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_red(o_red), .o_green(o_green), .o_slot_state(o_slot_state),
    .o_ack_state(o_ack_state));

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic conclude();
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  task automatic src(input int i, input logic v);
    @(posedge i_clock);
    sources[i] <= v;
  endtask

  // outputs are sampled at the falling edge, where they stand as the next rising edge sees them
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] rp;
    rp = 'x;
    @(posedge i_clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge i_clock);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rp = bresp;
      @(posedge i_clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        break;
      end
    end
    chk("write response", rp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tb;
    logic [1:0] rp;
    logic [31:0] d;
    rp = 'x;
    @(posedge i_clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge i_clock);
      ta = arvalid && arready;
      tb = rvalid;
      d = rdata;
      rp = rresp;
      @(posedge i_clock);
      if (ta) arvalid <= 1'b0;
      if (tb) begin
        rready <= 1'b0;
        break;
      end
    end
    chk("read response", rp, er);
    if (er === RESP_OKAY) chk("read data", d, ed);
  endtask

  task automatic lamp(input int l, input logic r, input logic g);
    chk("red", o_red[l], r);
    chk("green", o_green[l], g);
  endtask

  // lit cycles of a colour over two blink half periods
  function automatic int lit(input int c, input bit red);
    if (red) return (c == 1) ? 2 * HALF : (c == 2) ? HALF : 0;
    return (c == 0) ? 2 * HALF : (c == 3) ? HALF : 0;
  endfunction

  initial begin
    #1000000;
    n_errors++;
    conclude();
  end

  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    int nr, ng;
    bit same;
    repeat (6) @(posedge i_clock);
    i_srst <= 1'b0;
    tick(1);
    rd(8'h08, 32'h1, RESP_OKAY);
    rd(8'h04, 32'h0, RESP_OKAY);
    chk("green lamps", o_green, 32'h7f);
    chk("red lamps", o_red, 32'h0);
    rd(8'hf0, 32'h0, RESP_SLVERR);
    rd(8'he2, 32'h0, RESP_SLVERR);
    wr(8'h21, 32'h1, 4'hf, RESP_SLVERR);
    wr(8'h0c, 32'hff, 4'hf, RESP_OKAY);
    rd(8'h0c, 32'h0, RESP_OKAY);
    wr(8'ha8, 32'hffffff03, 4'h1, RESP_OKAY);
    rd(8'ha8, 32'h3, RESP_OKAY);
    // lamp 1: slot 0 on source 3, slot 4 on source 63
    wr(8'h20, 32'h3f000003, 4'hf, RESP_OKAY);
    src(63, 1'b1);
    tick(3);
    lamp(1, 1'b1, 1'b0);
    chk("slot state", o_slot_state[9], 32'h1);
    rd(8'h2c, 32'h50, RESP_OKAY);
    src(63, 1'b0);
    tick(3);
    lamp(1, 1'b0, 1'b1);
    wr(8'h24, 32'h4, 4'hf, RESP_OKAY);
    tick(3);
    lamp(1, 1'b1, 1'b0);
    chk("slot state", o_slot_state[7], 32'h1);
    // lamps 2 and 3 share source 0 and four colour pairs, each colour once as on and once as off
    for (int c = 0; c < 4; c++) begin
      wr(8'h48, 32'(c + 4 * ((c + 1) % 4)), 4'hf, RESP_OKAY);
      wr(8'h68, 32'(c + 4 * ((c + 1) % 4)), 4'hf, RESP_OKAY);
      for (int v = 0; v < 2; v++) begin
        src(0, v[0]);
        tick(3);
        nr = 0;
        ng = 0;
        same = 1'b1;
        repeat (2 * HALF) begin
          @(negedge i_clock);
          nr += int'(o_red[2] === 1'b1);
          ng += int'(o_green[2] === 1'b1);
          if (o_red[2] !== o_red[3] || o_green[2] !== o_green[3]) same = 1'b0;
        end
        chk("red cycles", nr, lit(v ? c : (c + 1) % 4, 1'b1));
        chk("green cycles", ng, lit(v ? c : (c + 1) % 4, 1'b0));
        chk("flash phase", same, 32'h1);
      end
    end
    src(0, 1'b0);
    // lamp 4 latching: slot 0 on source 10, acknowledge on source 20
    wr(8'h80, 32'ha, 4'hf, RESP_OKAY);
    wr(8'h88, 32'h1411, 4'hf, RESP_OKAY);
    src(10, 1'b1);
    tick(3);
    lamp(4, 1'b1, 1'b0);
    src(10, 1'b0);
    tick(3);
    lamp(4, 1'b1, 1'b0);
    rd(8'h8c, 32'hc0, RESP_OKAY);
    src(10, 1'b1);
    src(20, 1'b1);
    tick(3);
    lamp(4, 1'b1, 1'b0);
    chk("ack state", o_ack_state[4], 32'h1);
    chk("slot state", o_slot_state[20], 32'h1);
    src(10, 1'b0);
    tick(3);
    lamp(4, 1'b0, 1'b1);
    wr(8'h88, 32'h1421, 4'hf, RESP_OKAY);
    tick(3);
    chk("ack state", o_ack_state[4], 32'h0);
    src(10, 1'b1);
    tick(3);
    src(10, 1'b0);
    tick(3);
    lamp(4, 1'b1, 1'b0);
    wr(8'h88, 32'h1431, 4'hf, RESP_OKAY);
    rd(8'h88, 32'h1401, RESP_OKAY);
    tick(3);
    lamp(4, 1'b0, 1'b1);
    conclude();
  end
endmodule
